/* rtl/cpu_bus_cycle_sequencer.v */
// Bus cycle sequencer for exception entries, trap, test-and-set, multiple moves and block move.
// Summary of operation
// - Reset entry reads the vector upper word, then vector plus two, idles one state, then fetches at the start address.
// - Interrupt entry prefetches, idles one state, pushes low, high and extended control words, reads both vector words, idles and fetches the handler.
// - The interrupt prefetch reads saved PC plus two, but becomes an idle state when waking from sleep or standby.
// - A software trap fetches the next word, idles, pushes three words, reads both vector words, idles and fetches the handler.
// - Test-and-set fetches two words, reads the operand byte locked, writes it back with bit 7 set to the same address, and only pointers 0, 1, 4 and 5 are legal.
// - Multi-register store fetches two words, idles, then does one stack write pair per register for two, three or four registers.
// - Multi-register store and load accept only registers 0 through 6 in the list.
// - Block move reads from the source pointer and writes to the destination pointer, each incremented by one per byte.
// - Block move count is the initial byte or word count and a zero count runs no transfer cycles.
`timescale 1ns/1ps
`default_nettype none
`include "seq_consts.vh"
module cpu_bus_cycle_sequencer (
  input wire clock_in,
  input wire rstn_in,
  input wire start_in,
  input wire [2:0] op_in,
  input wire wake_in,
  input wire [31:0] vector_address_in,
  input wire [31:0] pc_in,
  input wire [31:0] sp_in,
  input wire [7:0] condition_code_word_in,
  input wire [7:0] extended_control_word_in,
  input wire [2:0] pointer_sel_in,
  input wire [31:0] pointer_value_in,
  input wire [2:0] first_reg_in,
  input wire [2:0] reg_count_in,
  input wire [31:0] reg_value_in,
  input wire [31:0] source_pointer_reg_in,
  input wire [31:0] dest_pointer_reg_in,
  input wire [15:0] count_in,
  input wire count_word_in,
  input wire bus_ack_in,
  input wire [15:0] bus_rdata_in,
  output wire bus_req_out,
  output wire [31:0] bus_addr_out,
  output wire bus_write_out,
  output wire bus_word_out,
  output wire bus_lock_out,
  output wire [15:0] bus_wdata_out,
  output wire busy_out,
  output reg done_out,
  output reg illegal_out,
  output reg [31:0] handler_addr_out,
  output reg [31:0] sp_out,
  output reg [31:0] source_pointer_reg_out,
  output reg [31:0] dest_pointer_reg_out,
  output reg [2:0] reg_index_out,
  output reg [31:0] load_data_out,
  output reg load_write_out
);
  localparam S_IDLE = 4'b0001;
  localparam S_STEP = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_DONE = 4'b1000;

  reg [3:0] state_reg;
  reg [2:0] op_reg;
  reg [3:0] idx_reg;
  reg wake_reg;
  reg [31:0] pc_reg;
  reg [31:0] vec_reg;
  reg [31:0] ea_reg;
  reg [15:0] rep_reg;
  reg [7:0] ccr_reg;
  reg [7:0] exr_reg;
  reg go_reg;
  reg [31:0] addr_reg;
  reg write_reg;
  reg word_reg;
  reg lock_reg;
  reg [15:0] wdata_reg;
  wire cyc_done;
  wire [15:0] rdata;
  wire [4:0] step;

  function [4:0] step_of;
    input [2:0] op;
    input [3:0] idx;
    reg [49:0] seq;
    begin
      seq = 50'h0;
      case (op)
        `OP_RESET: seq = {25'h0, `ST_END, `ST_FETCH_H, `ST_INT, `ST_VEC_LO, `ST_VEC_HI};
        `OP_IRQ: seq = {`ST_END, `ST_FETCH_H, `ST_INT, `ST_VEC_LO, `ST_VEC_HI,
          `ST_PUSH_X, `ST_PUSH_H, `ST_PUSH_L, `ST_INT, `ST_PREF};
        `OP_TRAP: seq = {`ST_END, `ST_FETCH_H, `ST_INT, `ST_VEC_LO, `ST_VEC_HI,
          `ST_PUSH_X, `ST_PUSH_H, `ST_PUSH_L, `ST_INT, `ST_FETCH};
        `OP_TAS: seq = {25'h0, `ST_END, `ST_WR_BYTE, `ST_RD_LOCK, `ST_FETCH, `ST_FETCH};
        `OP_STM: seq = {15'h0, `ST_END, `ST_LOOP, `ST_PAIR_L, `ST_PAIR_H, `ST_INT,
          `ST_FETCH, `ST_FETCH};
        `OP_LDM: seq = {15'h0, `ST_END, `ST_LOOP, `ST_POP_L, `ST_POP_H, `ST_INT,
          `ST_FETCH, `ST_FETCH};
        `OP_MOVE: seq = {25'h0, `ST_END, `ST_LOOP, `ST_MWR, `ST_MRD, `ST_MCHK};
        default: seq = 50'h0;
      endcase
      step_of = seq[idx * 5 +: 5];
    end
  endfunction

  function legal_of;
    input [2:0] op;
    input [2:0] psel;
    input [2:0] first;
    input [2:0] cnt;
    reg [7:0] ptr_ok;
    begin
      ptr_ok = `TAS_PTR_OK;
      case (op)
        `OP_TAS: legal_of = ptr_ok[psel];
        `OP_STM, `OP_LDM: legal_of = (cnt >= `MIN_LIST) && (cnt <= `MAX_LIST) &&
          ({1'b0, first} + {1'b0, cnt} - 4'h1 <= `LAST_LIST_REG);
        `OP_RESET, `OP_IRQ, `OP_TRAP, `OP_MOVE: legal_of = 1'b1;
        default: legal_of = 1'b0;
      endcase
    end
  endfunction

  assign step = step_of(op_reg, idx_reg);
  assign busy_out = !state_reg[0];

  bus_cycle_unit u_bus (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .go_in(go_reg),
    .addr_in(addr_reg),
    .write_in(write_reg),
    .word_in(word_reg),
    .lock_in(lock_reg),
    .wdata_in(wdata_reg),
    .bus_ack_in(bus_ack_in),
    .bus_rdata_in(bus_rdata_in),
    .bus_req_out(bus_req_out),
    .bus_addr_out(bus_addr_out),
    .bus_write_out(bus_write_out),
    .bus_word_out(bus_word_out),
    .bus_lock_out(bus_lock_out),
    .bus_wdata_out(bus_wdata_out),
    .done_out(cyc_done),
    .rdata_out(rdata)
  );

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= S_IDLE;
      op_reg <= 3'h0;
      idx_reg <= 4'h0;
      wake_reg <= 1'b0;
      pc_reg <= 32'h0000_0000;
      vec_reg <= 32'h0000_0000;
      ea_reg <= 32'h0000_0000;
      rep_reg <= 16'h0000;
      ccr_reg <= 8'h00;
      exr_reg <= 8'h00;
      go_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      write_reg <= 1'b0;
      word_reg <= 1'b0;
      lock_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      done_out <= 1'b0;
      illegal_out <= 1'b0;
      handler_addr_out <= 32'h0000_0000;
      sp_out <= 32'h0000_0000;
      source_pointer_reg_out <= 32'h0000_0000;
      dest_pointer_reg_out <= 32'h0000_0000;
      reg_index_out <= 3'h0;
      load_data_out <= 32'h0000_0000;
      load_write_out <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      done_out <= 1'b0;
      illegal_out <= 1'b0;
      load_write_out <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_in) begin
            if (legal_of(op_in, pointer_sel_in, first_reg_in, reg_count_in)) begin
              state_reg <= S_STEP;
            end else begin
              illegal_out <= 1'b1;
            end
            op_reg <= op_in;
            idx_reg <= 4'h0;
            wake_reg <= wake_in;
            pc_reg <= pc_in;
            sp_out <= sp_in;
            ea_reg <= pointer_value_in;
            ccr_reg <= condition_code_word_in;
            exr_reg <= extended_control_word_in;
            source_pointer_reg_out <= source_pointer_reg_in;
            dest_pointer_reg_out <= dest_pointer_reg_in;
            if (op_in == `OP_MOVE) begin
              rep_reg <= count_word_in ? count_in : {8'h00, count_in[7:0]};
            end else begin
              rep_reg <= {13'h0000, reg_count_in};
            end
            if (op_in == `OP_STM) begin
              reg_index_out <= first_reg_in + reg_count_in - 3'h1;
            end else begin
              reg_index_out <= first_reg_in;
            end
          end
        end
        S_STEP: begin
          write_reg <= 1'b0;
          word_reg <= 1'b1;
          lock_reg <= 1'b0;
          wdata_reg <= 16'h0000;
          state_reg <= S_WAIT;
          go_reg <= 1'b1;
          case (step)
            `ST_FETCH: addr_reg <= pc_reg;
            `ST_FETCH_H: addr_reg <= vec_reg;
            `ST_PREF: begin
              addr_reg <= pc_reg + `WORD_STEP;
              if (wake_reg) begin
                go_reg <= 1'b0;
                state_reg <= S_STEP;
                idx_reg <= idx_reg + 4'h1;
              end
            end
            `ST_PUSH_L, `ST_PUSH_H, `ST_PUSH_X: begin
              addr_reg <= sp_out - `WORD_STEP;
              write_reg <= 1'b1;
              if (step == `ST_PUSH_L) begin
                wdata_reg <= pc_reg[15:0];
              end else if (step == `ST_PUSH_H) begin
                wdata_reg <= {ccr_reg, pc_reg[23:16]};
              end else begin
                wdata_reg <= {exr_reg, 8'h00};
              end
            end
            `ST_VEC_HI: begin
              addr_reg <= vector_address_in;
              lock_reg <= 1'b1;
            end
            `ST_VEC_LO: addr_reg <= vector_address_in + `WORD_STEP;
            `ST_RD_LOCK: begin
              addr_reg <= ea_reg;
              word_reg <= 1'b0;
              lock_reg <= 1'b1;
            end
            `ST_WR_BYTE: begin
              addr_reg <= ea_reg;
              word_reg <= 1'b0;
              write_reg <= 1'b1;
              wdata_reg <= {8'h00, rdata[7:0] | `TAS_SET_BIT};
            end
            `ST_PAIR_H: begin
              addr_reg <= sp_out - `PAIR_STEP;
              write_reg <= 1'b1;
              wdata_reg <= reg_value_in[31:16];
            end
            `ST_PAIR_L: begin
              addr_reg <= sp_out + `WORD_STEP;
              write_reg <= 1'b1;
              wdata_reg <= reg_value_in[15:0];
            end
            `ST_POP_H: addr_reg <= sp_out;
            `ST_POP_L: addr_reg <= sp_out + `WORD_STEP;
            `ST_MRD: begin
              addr_reg <= source_pointer_reg_out;
              word_reg <= 1'b0;
            end
            `ST_MWR: begin
              addr_reg <= dest_pointer_reg_out;
              word_reg <= 1'b0;
              write_reg <= 1'b1;
              wdata_reg <= {8'h00, rdata[7:0]};
            end
            default: begin
              go_reg <= 1'b0;
              state_reg <= S_STEP;
              idx_reg <= idx_reg + 4'h1;
              if (step == `ST_END) begin
                state_reg <= S_DONE;
              end else if (step == `ST_MCHK && rep_reg == 16'h0000) begin
                state_reg <= S_DONE;
              end else if (step == `ST_LOOP) begin
                rep_reg <= rep_reg - 16'h0001;
                if (op_reg == `OP_STM) begin
                  reg_index_out <= reg_index_out - 3'h1;
                end else begin
                  reg_index_out <= reg_index_out + 3'h1;
                end
                if (rep_reg != 16'h0001) begin
                  idx_reg <= idx_reg - 4'h2;
                end
              end
            end
          endcase
        end
        S_WAIT: begin
          if (cyc_done) begin
            state_reg <= S_STEP;
            idx_reg <= idx_reg + 4'h1;
            case (step)
              `ST_FETCH: pc_reg <= pc_reg + `WORD_STEP;
              `ST_FETCH_H: pc_reg <= vec_reg + `WORD_STEP;
              `ST_PUSH_L, `ST_PUSH_H, `ST_PUSH_X: sp_out <= sp_out - `WORD_STEP;
              `ST_VEC_HI: vec_reg[31:16] <= rdata;
              `ST_VEC_LO: begin
                vec_reg[15:0] <= rdata;
                handler_addr_out <= {vec_reg[31:16], rdata};
              end
              `ST_PAIR_H: sp_out <= sp_out - `PAIR_STEP;
              `ST_POP_H: load_data_out[31:16] <= rdata;
              `ST_POP_L: begin
                load_data_out[15:0] <= rdata;
                load_write_out <= 1'b1;
                sp_out <= sp_out + `PAIR_STEP;
              end
              `ST_MRD: source_pointer_reg_out <= source_pointer_reg_out + `MOVE_STEP;
              `ST_MWR: dest_pointer_reg_out <= dest_pointer_reg_out + `MOVE_STEP;
              default: pc_reg <= pc_reg;
            endcase
          end
        end
        S_DONE: begin
          done_out <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* pkg/seq_consts.vh */
// Constants shared by the bus cycle sequencer files.
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH
`define OP_RESET 3'h0
`define OP_IRQ 3'h1
`define OP_TRAP 3'h2
`define OP_TAS 3'h3
`define OP_STM 3'h4
`define OP_LDM 3'h5
`define OP_MOVE 3'h6
`define ST_END 5'h00
`define ST_FETCH 5'h01
`define ST_INT 5'h02
`define ST_PUSH_L 5'h03
`define ST_PUSH_H 5'h04
`define ST_PUSH_X 5'h05
`define ST_VEC_HI 5'h06
`define ST_VEC_LO 5'h07
`define ST_FETCH_H 5'h08
`define ST_PREF 5'h09
`define ST_RD_LOCK 5'h0a
`define ST_WR_BYTE 5'h0b
`define ST_PAIR_H 5'h0c
`define ST_PAIR_L 5'h0d
`define ST_POP_H 5'h0e
`define ST_POP_L 5'h0f
`define ST_MCHK 5'h10
`define ST_MRD 5'h11
`define ST_MWR 5'h12
`define ST_LOOP 5'h13
`define WORD_STEP 32'h0000_0002
`define PAIR_STEP 32'h0000_0004
`define MOVE_STEP 32'h0000_0001
`define TAS_SET_BIT 8'h80
`define LAST_LIST_REG 4'h6
`define MIN_LIST 3'h2
`define MAX_LIST 3'h4
`define TAS_PTR_OK 8'h33
`endif

/* rtl/bus_cycle_unit.v */
// Single bus cycle issuer that holds a request until the memory acknowledges it.
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_unit (
  input wire clock_in,
  input wire rstn_in,
  input wire go_in,
  input wire [31:0] addr_in,
  input wire write_in,
  input wire word_in,
  input wire lock_in,
  input wire [15:0] wdata_in,
  input wire bus_ack_in,
  input wire [15:0] bus_rdata_in,
  output reg bus_req_out,
  output reg [31:0] bus_addr_out,
  output reg bus_write_out,
  output reg bus_word_out,
  output reg bus_lock_out,
  output reg [15:0] bus_wdata_out,
  output reg done_out,
  output reg [15:0] rdata_out
);
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_req_out <= 1'b0;
      bus_addr_out <= 32'h0000_0000;
      bus_write_out <= 1'b0;
      bus_word_out <= 1'b0;
      bus_lock_out <= 1'b0;
      bus_wdata_out <= 16'h0000;
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      if (go_in && !bus_req_out) begin
        bus_req_out <= 1'b1;
        bus_addr_out <= addr_in;
        bus_write_out <= write_in;
        bus_word_out <= word_in;
        bus_lock_out <= lock_in;
        bus_wdata_out <= wdata_in;
      end else if (bus_req_out && bus_ack_in) begin
        bus_req_out <= 1'b0;
        bus_lock_out <= 1'b0;
        done_out <= 1'b1;
        if (!bus_write_out) begin
          rdata_out <= bus_rdata_in;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* dv/seq_monitor.sv */
// Timing checker for the bus cycle sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module seq_monitor (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [2:0] op_in,
  input wire logic [2:0] pointer_sel_in,
  input wire logic [2:0] first_reg_in,
  input wire logic [2:0] reg_count_in,
  input wire logic [31:0] vector_address_in,
  input wire logic [15:0] count_in,
  input wire logic count_word_in,
  input wire logic bus_ack_in,
  input wire logic bus_req_out,
  input wire logic [31:0] bus_addr_out,
  input wire logic bus_write_out,
  input wire logic bus_word_out,
  input wire logic bus_lock_out,
  input wire logic busy_out,
  input wire logic illegal_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  wire go = start_in && !busy_out;
  wire [3:0] top_reg = {1'b0, first_reg_in} + {1'b0, reg_count_in};
  a_req_holds: assert property (
    bus_req_out && !bus_ack_in |=> bus_req_out && $stable(bus_addr_out) && $stable(bus_write_out))
    else $error("bus request changed before ack");
  a_req_drops: assert property (
    bus_req_out && bus_ack_in |=> !bus_req_out ##1 !bus_req_out)
    else $error("bus request not released after ack");
  a_reset_vector_read: assert property (
    go && op_in == 3'h0 |-> ##[1:4] (bus_req_out && bus_addr_out == vector_address_in
    && bus_lock_out && bus_word_out && !bus_write_out))
    else $error("reset entry did not read the vector");
  a_reset_busy: assert property (
    go && op_in == 3'h0 |=> busy_out [*3]) else $error("reset entry not busy");
  a_lock_is_read: assert property (
    bus_req_out && bus_lock_out |-> !bus_write_out) else $error("locked write");
  a_tas_bad_ptr: assert property (
    go && op_in == 3'h3 && !(pointer_sel_in inside {3'h0, 3'h1, 3'h4, 3'h5})
    |=> illegal_out && !bus_req_out) else $error("bad pointer accepted");
  a_list_bad: assert property (
    go && (op_in == 3'h4 || op_in == 3'h5) && (reg_count_in < 3'h2 || reg_count_in > 3'h4
    || top_reg > 4'h7) |=> illegal_out) else $error("bad register list accepted");
  a_entry_legal: assert property (
    go && op_in <= 3'h2 |=> !illegal_out) else $error("entry refused");
  a_move_zero: assert property (
    go && op_in == 3'h6 && (count_word_in ? count_in == 16'h0000 : count_in[7:0] == 8'h00)
    |=> !bus_req_out [*4]) else $error("zero count moved data");
endmodule
bind cpu_bus_cycle_sequencer seq_monitor mon_u (.clock_in, .rstn_in, .start_in, .op_in,
  .pointer_sel_in, .first_reg_in, .reg_count_in, .vector_address_in, .count_in, .count_word_in,
  .bus_ack_in, .bus_req_out, .bus_addr_out, .bus_write_out, .bus_word_out, .bus_lock_out,
  .busy_out, .illegal_out);
`default_nettype wire

/* dv/mem_model.sv */
// Memory model that acknowledges bus cycles with stalls and returns address-derived data.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic stall_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  // Read data is only valid with ack; otherwise it toggles every cycle.
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else if (req_in && !ack_out && !stall_in) begin
      ack_out <= 1'b1;
      rdata_out <= addr_in[15:0] ^ 16'ha5c3;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the bus cycle sequencer against a memory model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_in, rstn_in, start_in, wake_in, count_word_in, stall;
  logic [2:0] op_in, pointer_sel_in, first_reg_in, reg_count_in;
  logic [31:0] vec, pc, sp, ptr, src, dst, hv, s;
  logic [7:0] condition_code_word, extended_control_word;
  logic [15:0] count_in;
  wire req, wr, wd, lk, busy, done, ill, ack, ldw;
  wire [31:0] addr, hnd, spo, srco, dsto, ldo;
  wire [15:0] wdat, rdat;
  wire [2:0] ridx;
  int seed = 32'h8725_a8e5;
  int n_errors = 0;
  int check_count = 0;
  logic [50:0] got_q[$], exp_q[$];
  logic [15:0] msk_q[$];
  logic [34:0] ld_q[$];
  function automatic logic [15:0] md(input logic [31:0] a);
    return a[15:0] ^ 16'ha5c3;
  endfunction
  function automatic logic [31:0] rv(input logic [2:0] i);
    return {8'h5a, 5'h00, i, 8'hc3, 5'h00, i};
  endfunction
  cpu_bus_cycle_sequencer dut_u (.clock_in, .rstn_in, .start_in, .op_in, .wake_in,
    .vector_address_in(vec), .pc_in(pc), .sp_in(sp), .condition_code_word_in(condition_code_word),
    .extended_control_word_in(extended_control_word), .pointer_sel_in, .pointer_value_in(ptr), .first_reg_in,
    .reg_count_in, .reg_value_in(rv(ridx)), .source_pointer_reg_in(src),
    .dest_pointer_reg_in(dst), .count_in, .count_word_in, .bus_ack_in(ack), .bus_rdata_in(rdat),
    .bus_req_out(req), .bus_addr_out(addr), .bus_write_out(wr), .bus_word_out(wd),
    .bus_lock_out(lk), .bus_wdata_out(wdat), .busy_out(busy), .done_out(done),
    .illegal_out(ill), .handler_addr_out(hnd), .sp_out(spo), .source_pointer_reg_out(srco),
    .dest_pointer_reg_out(dsto), .reg_index_out(ridx), .load_data_out(ldo), .load_write_out(ldw));
  mem_model mem_u (.clock_in, .rstn_in, .stall_in(stall), .req_in(req), .addr_in(addr),
    .ack_out(ack), .rdata_out(rdat));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (req === 1'b1 && ack === 1'b1)
      got_q.push_back({wr, wd, lk, addr, wr ? (wd ? wdat : {8'h00, wdat[7:0]}) : 16'h0000});
    if (ldw === 1'b1)
      ld_q.push_back({ridx, ldo});
    #1 stall = ($random(seed) & 3) == 0;
  end
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] g, input logic [63:0] e, input string t);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, t, g, e);
    end
  endtask
  task automatic ex(input logic w, d, l, input logic [31:0] a, input logic [15:0] v, m);
    exp_q.push_back({w, d, l, a, v & m});
    msk_q.push_back(m);
  endtask
  task automatic vt();
    ex(0, 1, 1, vec, 0, 0);
    ex(0, 1, 0, vec + 2, 0, 0);
    ex(0, 1, 0, hv, 0, 0);
  endtask
  task automatic run(input logic [2:0] op, input logic bad);
    int k;
    @(posedge clock_in);
    #1 op_in = op;
    start_in = 1'b1;
    got_q.delete();
    ld_q.delete();
    @(posedge clock_in);
    #1 start_in = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1 && ill !== 1'b1; k++) begin
      @(posedge clock_in);
      #1;
    end
    cmp(k < 3000, 1, "completion");
    cmp(ill, bad, "refusal");
    cmp(got_q.size(), exp_q.size(), "cycle count");
    foreach (exp_q[i])
      if (i < got_q.size()) cmp({got_q[i][50:16], got_q[i][15:0] & msk_q[i]}, exp_q[i], "cycle");
    exp_q.delete();
    msk_q.delete();
  endtask
  initial begin
    int r, m, j, n, c;
    logic bad;
    {start_in, wake_in, count_word_in, op_in, pointer_sel_in, first_reg_in} = '0;
    {vec, pc, sp, ptr, src, dst, condition_code_word, extended_control_word, count_in, reg_count_in} = '0;
    rstn_in = 1'b0;
    repeat (16) @(posedge clock_in);
    #1 rstn_in = 1'b1;
    for (r = 0; r < 3; r++) begin
      vec = $random(seed) & 32'h00ff_fffc;
      pc = $random(seed) & 32'h00ff_fffe;
      sp = ($random(seed) & 32'h00ff_fff0) + 32'h0000_0100;
      {condition_code_word, extended_control_word} = 16'($random(seed));
      hv = {md(vec), md(vec + 2)};
      vt();
      run(3'h0, 0);
      cmp(hnd, hv, "handler");
      for (m = 0; m < 3; m++) begin
        wake_in = (m == 1);
        if (m != 1) ex(0, 1, 0, m == 2 ? pc : pc + 2, 0, 0);
        s = m == 2 ? pc + 2 : pc;
        ex(1, 1, 0, sp - 2, s[15:0], 16'hffff);
        ex(1, 1, 0, sp - 4, {condition_code_word, s[23:16]}, 16'hffff);
        ex(1, 1, 0, sp - 6, {extended_control_word, 8'h00}, 16'hffff);
        vt();
        run(m == 2 ? 3'h2 : 3'h1, 0);
      end
      for (m = 0; m < 8; m++) begin
        pointer_sel_in = 3'(m);
        ptr = $random(seed);
        bad = !(m inside {0, 1, 4, 5});
        if (!bad) begin
          ex(0, 1, 0, pc, 0, 0);
          ex(0, 1, 0, pc + 2, 0, 0);
          ex(0, 0, 1, ptr, 0, 0);
          ex(1, 0, 0, ptr, md(ptr) | 16'h0080, 16'h00ff);
        end
        run(3'h3, bad);
      end
      for (m = 0; m < 12; m++) begin
        j = m % 6;
        c = j < 3 ? j + 2 : (j == 3 ? 1 : (j == 4 ? 5 : 3));
        bad = j > 2;
        first_reg_in = 3'(j < 3 ? $unsigned($random(seed)) % (8 - c) : (j == 5 ? 5 : 0));
        reg_count_in = 3'(c);
        if (!bad) begin
          ex(0, 1, 0, pc, 0, 0);
          ex(0, 1, 0, pc + 2, 0, 0);
          for (n = 0; n < c; n++) begin
            s = m < 6 ? sp - 4 * (n + 1) : sp + 4 * n;
            hv = rv(3'(m < 6 ? first_reg_in + c - 1 - n : first_reg_in + n));
            ex(m < 6, 1, 0, s, hv[31:16], {16{m < 6}});
            ex(m < 6, 1, 0, s + 2, hv[15:0], {16{m < 6}});
          end
        end
        run(m < 6 ? 3'h4 : 3'h5, bad);
        if (!bad) cmp(spo, m < 6 ? sp - 4 * c : sp + 4 * c, "stack");
        cmp(ld_q.size(), (m < 6 || bad) ? 0 : c, "load count");
        foreach (ld_q[i])
          cmp(ld_q[i], {3'(first_reg_in+i), md(sp+4*i), md(sp+4*i+2)}, "load");
      end
      for (m = 0; m < 4; m++) begin
        count_word_in = m[0];
        n = m < 2 ? 0 : 1 + $unsigned($random(seed)) % 5;
        count_in = count_word_in ? 16'(n) : {8'h03, 8'(n)};
        src = $random(seed);
        dst = $random(seed);
        for (j = 0; j < n; j++) begin
          ex(0, 0, 0, src + j, 0, 0);
          ex(1, 0, 0, dst + j, md(src + j), 16'h00ff);
        end
        run(3'h6, 0);
        if (n > 0) cmp(srco, src + n, "source");
        cmp(dsto, dst + n, "dest");
      end
    end
    print_verdict();
  end
  initial begin
    #5_000_000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
